// ==== sim/i2csf_assertions.sv ====
// Purpose: port-level checks for i2csf_top
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to the top module at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module i2csf_assertions
  import i2csf_pkg::*;
(
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  // pins and dma
  input wire logic        scl_o,
  input wire logic        scl_oe_o,
  input wire logic        sda_o,
  input wire logic        rx_dma_req_o,
  input wire logic        rx_dma_ack_i,
  input wire logic [7:0]  rx_dma_data_o
);
  // ******************************
  // access decode
  // ******************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic acc_w;
  logic acc_r;
  logic pop_w;
  // completed transfers only; a stalled access must not count
  assign acc_w = psel_i & penable_i & pready_o & pwrite_i;
  assign acc_r = psel_i & penable_i & pready_o & ~pwrite_i;
  assign pop_w = acc_r & (paddr_i == OFS_RXDATA);
  sequence s_setup(a);
    psel_i && !penable_i && !pwrite_i && paddr_i == a;
  endsequence
  property p_back(a);
    acc_w && paddr_i == a ##2 s_setup(a) ##1 acc_r
      |-> prdata_o[9:0] == $past(pwdata_i[9:0], 3);
  endproperty
  // ******************************
  // properties
  // ******************************
  a_open_drain_low:
    assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("pin output driven high");
  a_stretch_release:
    assert property (pop_w && scl_oe_o |-> ##[1:4] !scl_oe_o)
    else $error("clock stretch kept after a pop");
  a_dma_head_hold:
    assert property (rx_dma_req_o && !rx_dma_ack_i && !pop_w
      |=> !rx_dma_req_o || $stable(rx_dma_data_o))
    else $error("dma head byte changed without a pop");
  a_rxdata_rsv:
    assert property (pop_w |-> prdata_o[31:8] == 24'h0)
    else $error("rx data upper bits not zero");
  a_thr_rsv:
    assert property (acc_r && (paddr_i == OFS_TXTHR || paddr_i == OFS_RXTHR)
      |-> prdata_o[31:10] == 22'h0)
    else $error("threshold upper bits not zero");
  a_txthr_back:
    assert property (p_back(OFS_TXTHR))
    else $error("tx threshold readback wrong");
  a_rxthr_back:
    assert property (p_back(OFS_RXTHR))
    else $error("rx threshold readback wrong");
  a_status_slave_op:
    assert property (acc_r && paddr_i == OFS_XSTAT && prdata_o[3:2] != XS_NOP
      |-> prdata_o[1] == 1'b1)
    else $error("slave status with master op code");
  a_status_rsv:
    assert property (acc_r && paddr_i == OFS_XSTAT
      |-> prdata_o[28:19] == 10'h0 && prdata_o[31:30] == 2'h0)
    else $error("status reserved bits not zero");
endmodule : i2csf_assertions
bind i2csf_top i2csf_assertions i_chk (.core_clk_i, .rstn_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .scl_o,
  .scl_oe_o, .sda_o, .rx_dma_req_o, .rx_dma_ack_i, .rx_dma_data_o);
`default_nettype wire

// ==== sim/i2csf_i2c_master.sv ====
// Purpose: two-wire bus master that addresses the slave under test
// Assumes: open-drain wires resolved in the bench, pull-ups on both
// Notes:   one bit is 8 core clocks, 400 ns; waits on stretched scl
`timescale 1ns/1ps
`default_nettype none
module i2csf_i2c_master (
  // clock and resolved wires
  input  wire logic clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  // pull-downs, high pulls the wire low
  output var logic  scl_pull_o,
  output var logic  sda_pull_o
);
  // ******************************
  // bus primitives
  // ******************************
  // idle: both lines released to their pull-ups
  initial
  begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
  end
  task automatic qp(input int n);
    repeat (n) @(posedge clk_i);
  endtask : qp
  // sda moves mid-low phase, clear of the slave's late ack release
  task automatic bitx(input logic b, output logic r);
    int t;
    qp(2);
    sda_pull_o <= !b;
    qp(2);
    scl_pull_o <= 1'b0;
    t = 0;
    while (scl_i !== 1'b1 && t < 3000)
    begin
      @(posedge clk_i);
      t++;
    end
    qp(1);
    r = sda_i;
    qp(2);
    scl_pull_o <= 1'b1;
  endtask : bitx
  task automatic start();
    qp(4);
    sda_pull_o <= 1'b0;
    qp(2);
    scl_pull_o <= 1'b0;
    qp(2);
    sda_pull_o <= 1'b1;
    qp(2);
    scl_pull_o <= 1'b1;
  endtask : start
  task automatic stop();
    qp(2);
    sda_pull_o <= 1'b1;
    qp(2);
    scl_pull_o <= 1'b0;
    qp(2);
    sda_pull_o <= 1'b0;
    qp(4);
  endtask : stop
  // address goes msb first, payload lsb first
  task automatic xbyte(input logic [7:0] d, input logic msb,
                       input logic mack, output logic ack);
    logic r;
    for (int i = 0; i < 8; i++)
      bitx(msb ? d[7 - i] : d[i], r);
    bitx(mack, ack);
  endtask : xbyte
endmodule : i2csf_i2c_master
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: self-checking bench for i2csf_top
// Assumes: zero-wait apb, rx fifo shrunk to four entries
// Notes:   register table rows first, bus transfers after
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import i2csf_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } i2csf_row_t;
  // ******************************
  // signals
  // ******************************
  logic        core_clk_i, rstn_i, ce_i, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i, rx_dma_data_o;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic        pready_o, pslverr_o, scl_o, scl_oe_o, sda_o, sda_oe_o;
  logic [9:0]  tx_level_i;
  logic        rx_dma_req_o, rx_dma_ack_i, irq_o, ack, err;
  logic        scl_pull, sda_pull, scl_w, sda_w;
  int          failures, checked, k;
  int          cyc = 0;
  i2csf_row_t  rows [8] = '{
    '{1'b0, OFS_TXTHR, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFS_RXTHR, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFS_XSTAT, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFS_RXDATA, 32'h0, 32'h0, 1'b0},
    '{1'b1, OFS_TXTHR, 32'hffff_ffff, 32'h3ff, 1'b0},
    '{1'b1, OFS_RXTHR, 32'hffff_ffff, 32'h3ff, 1'b0},
    '{1'b1, OFS_RXDATA, 32'hffff_ffff, 32'h0, 1'b0},
    '{1'b0, 8'h3c, 32'h0, 32'h0, 1'b1}};
  // open-drain wires with pull-ups
  assign scl_w = !scl_pull && (scl_oe_o ? scl_o : 1'b1);
  assign sda_w = !sda_pull && (sda_oe_o ? sda_o : 1'b1);
  i2csf_top #(.RX_DEPTH(4)) i_dut (.core_clk_i, .rstn_i, .ce_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .scl_i(scl_w), .scl_o, .scl_oe_o, .sda_i(sda_w), .sda_o,
    .sda_oe_o, .tx_level_i, .rx_dma_req_o, .rx_dma_ack_i, .rx_dma_data_o,
    .irq_o);
  i2csf_i2c_master i_mst (.clk_i(core_clk_i), .scl_i(scl_w), .sda_i(sda_w),
    .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));
  // ******************************
  // tasks
  // ******************************
  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  // hang guard, well above the longest expected run
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      $display("[ERR] %0t run timed out", $time);
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] g, x, m);
    checked++;
    if ((g & m) !== (x & m))
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int t;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    t = 0;
    do
    begin
      @(posedge core_clk_i);
      t++;
    end while (pready_o !== 1'b1 && t < 50);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, m);
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, x, m);
  endtask : rdc
  task automatic wb(input logic [7:0] d, input logic msb);
    i_mst.xbyte(d, msb, 1'b1, ack);
    chk({31'h0, ack}, 32'h0, 32'h1);
  endtask : wb
  // ******************************
  // main sequence
  // ******************************
  initial
  begin
    {psel_i, penable_i, pwrite_i, rx_dma_ack_i} = 4'h0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    tx_level_i = 10'h000;
    ce_i = 1'b1;
    rstn_i = 1'b0;
    failures = 0;
    checked = 0;
    repeat (16) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].x, '1);
      chk({31'h0, err}, {31'h0, rows[i].e}, 32'h1);
    end
    wr(OFS_TXTHR, 32'h5);
    wr(OFS_RXTHR, 32'h2);
    wr(OFS_CTRL, 32'h0035_2a01);
    wr(OFS_MASK, 32'h4);
    // tx level at the limit flags, one above does not
    @(posedge core_clk_i) tx_level_i <= 10'h005;
    apb(1'b0, OFS_RAW, 32'h0, rd, err);
    rdc(OFS_RAW, 32'h1, 32'h3);
    @(posedge core_clk_i) tx_level_i <= 10'h006;
    apb(1'b0, OFS_RAW, 32'h0, rd, err);
    rdc(OFS_RAW, 32'h0, 32'h3);
    // write-to-slave on the primary address
    i_mst.start();
    wb({7'h2a, 1'b0}, 1'b1);
    chk({31'h0, irq_o}, 32'h1, 32'h1);
    wb(8'ha5, 1'b0);
    wb(8'h3c, 1'b0);
    rdc(OFS_XSTAT, 32'h2, 32'h2000_0003);
    i_mst.stop();
    rdc(OFS_XSTAT, 32'h0000_040a, 32'h2007_ff8f);
    rdc(OFS_RAW, 32'h6, 32'h6);
    @(negedge core_clk_i);
    chk({31'h0, irq_o}, 32'h0, 32'h1);
    rdc(OFS_RXDATA, 32'ha5, '1);
    rdc(OFS_RXDATA, 32'h3c, '1);
    rdc(OFS_RXDATA, 32'h0, '1);
    // secondary address, then a repeated start
    i_mst.start();
    wb({7'h35, 1'b0}, 1'b1);
    wb(8'h11, 1'b0);
    rdc(OFS_XSTAT, 32'h2000_0000, 32'h2000_0000);
    i_mst.start();
    rdc(OFS_XSTAT, 32'h0, 32'h2000_0000);
    i_mst.stop();
    rdc(OFS_RXDATA, 32'h11, '1);
    // read-from-slave, master acks three bytes
    i_mst.start();
    wb({7'h2a, 1'b1}, 1'b1);
    repeat (3) i_mst.xbyte(8'hff, 1'b0, 1'b0, ack);
    i_mst.stop();
    rdc(OFS_XSTAT, 32'h0000_060b, 32'h0007_fe0f);
    // general call with a last wire bit of one
    i_mst.start();
    wb(8'h00, 1'b1);
    wb(8'h80, 1'b0);
    i_mst.stop();
    rdc(OFS_XSTAT, 32'h100, 32'h180);
    apb(1'b0, OFS_RXDATA, 32'h0, rd, err);
    apb(1'b0, OFS_RXDATA, 32'h0, rd, err);
    // fill the four-entry fifo and watch the stretch
    i_mst.start();
    wb({7'h2a, 1'b0}, 1'b1);
    for (k = 1; k < 4; k++)
      wb(k[7:0], 1'b0);
    fork
      begin
        wb(8'h04, 1'b0);
        wb(8'h05, 1'b0);
      end
      begin
        for (k = 0; k < 400 && scl_oe_o !== 1'b1; k++)
          @(posedge core_clk_i);
        chk({31'h0, scl_w}, 32'h0, 32'h1);
        rdc(OFS_RXDATA, 32'h1, '1);
      end
    join
    i_mst.stop();
    for (k = 2; k < 6; k++)
      rdc(OFS_RXDATA, k, '1);
    // dma mode: request follows the fifo, ack pops
    wr(OFS_CTRL, 32'h0035_2a03);
    i_mst.start();
    wb({7'h2a, 1'b0}, 1'b1);
    wb(8'h5a, 1'b0);
    i_mst.stop();
    @(negedge core_clk_i);
    chk({rx_dma_req_o, 23'h0, rx_dma_data_o}, 32'h8000_005a, '1);
    @(posedge core_clk_i) rx_dma_ack_i <= 1'b1;
    @(posedge core_clk_i) rx_dma_ack_i <= 1'b0;
    @(negedge core_clk_i);
    chk({31'h0, rx_dma_req_o}, 32'h0, 32'h1);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire

// ==== src/i2csf_pkg.sv ====
// Purpose: constants and carriers for the i2c status/fifo/threshold block
// Assumes: apb register access, 32-bit data, byte addresses
// Notes:   offsets are byte addresses of aligned words
package i2csf_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_XSTAT  = 8'h14;
  localparam logic [7:0] OFS_RXDATA = 8'h18;
  localparam logic [7:0] OFS_TXTHR  = 8'h1c;
  localparam logic [7:0] OFS_RXTHR  = 8'h20;
  localparam logic [7:0] OFS_RAW    = 8'h30;
  localparam logic [7:0] OFS_MASK   = 8'h34;

  // ****************************************************************
  // reset values and limits
  // ****************************************************************
  localparam logic [31:0] REG_RST  = 32'h0000_0000;
  localparam logic [9:0]  THR_RST  = 10'h000;
  localparam logic [10:0] LEN_MAX  = 11'h7ff;
  localparam logic [7:0]  GCALL_AD = 8'h00;
  localparam logic [3:0]  BYTE_END = 4'h8;
  localparam logic [3:0]  ACK_END  = 4'h9;

  // ****************************************************************
  // status word encodings
  // ****************************************************************
  localparam logic [1:0] MASTER_WRITE_OP    = 2'h0;
  localparam logic [1:0] MASTER_READ_OP     = 2'h1;
  localparam logic [1:0] WRITE_TO_SLAVE_OP  = 2'h2;
  localparam logic [1:0] READ_FROM_SLAVE_OP = 2'h3;
  localparam logic [1:0] XS_NOP   = 2'h0;
  localparam logic [1:0] XS_BUSY  = 2'h1;
  localparam logic [1:0] XS_OK    = 2'h2;
  localparam logic [1:0] XS_ABORT = 2'h3;
  localparam logic [2:0] CAUSE_BERR_START = 3'h4;
  localparam logic [2:0] CAUSE_BERR_STOP  = 3'h5;
  localparam logic [2:0] OVERFLOW_ABORT   = 3'h6;
  localparam logic [1:0] RT_FRAME = 2'h0;
  localparam logic [1:0] RT_GCALL = 2'h1;
  localparam logic [1:0] HARDWARE_BROADCAST_CALL = 2'h2;

  // ****************************************************************
  // interrupt bit positions
  // ****************************************************************
  localparam int IRQ_TXNE = 0;
  localparam int IRQ_RXNF = 1;
  localparam int IRQ_SLAVE_WRITE_REQUEST_FLAG = 2;
  localparam int IRQ_OVF  = 3;
  localparam int IRQ_W    = 4;

  // transfer status word layout
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic       secondary_address_hit;
    logic [9:0] rsv_mid;
    logic [9:0] length;
    logic [1:0] rtype;
    logic [2:0] cause;
    logic [1:0] status;
    logic [1:0] op;
  } i2csf_xstat_t;

  // control register layout
  typedef struct packed {
    logic [8:0] rsv_hi;
    logic [6:0] secondary_slave_addr;
    logic       rsv_b15;
    logic [6:0] primary_slave_addr;
    logic [5:0] rsv_lo;
    logic       dma_mode;
    logic       peripheral_on;
  } i2csf_ctrl_t;

endpackage : i2csf_pkg

// ==== src/i2csf_top.sv ====
// Purpose: i2c slave receive path, status word, rx fifo, thresholds
// Assumes: scl/sda are open drain, sampled by core_clk_i
// Notes:   transmit data engine and master sequencing live elsewhere
// Function
// RULE1 - operation codes 00 01 10 11
// RULE2 - hardware general call reports type 10
// RULE3 - read/write-to-slave length gives payload bytes
// RULE4 - write/read-from-slave length counts transferred bytes
// RULE5 - over 2047 bytes: nack, set overflow
// RULE6 - overflow abort cause is 110
// RULE7 - read-from-slave overflow: continue, length zero
// RULE8 - dual flag shows which address matched
// RULE9 - dual flag cleared on stop/start/error/off; an overflow abort leaves it set until the next start, stop or off
// RULE10 - data read returns oldest byte, lsb first
// RULE11 - stretch scl low while fifo full
// RULE12 - slave write address sets request flag
// RULE13 - software drains fifo on nearly-full flag
// RULE14 - dma single requests follow fifo entries
// RULE15 - tx level at or below limit flags
// RULE16 - rx level at or above limit flags
// RULE17 - data read pops; empty reads zero
// RULE18 - reserved bits read zero, ignore writes
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module i2csf_top
  import i2csf_pkg::*;
#(
  parameter int RX_DEPTH = 16
)(
  // clock, reset, enable
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // i2c pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // transmit fifo level from tx path
  input  wire logic [9:0]  tx_level_i,
  // rx dma
  output logic             rx_dma_req_o,
  input  wire logic        rx_dma_ack_i,
  output logic      [7:0]  rx_dma_data_o,
  // interrupt
  output logic             irq_o
);

  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_AACK, S_RX, S_RHOLD, S_RACK, S_TX, S_WAIT
  } i2csf_state_t;

  // ****************************************************************
  // registers
  // ****************************************************************
  i2csf_ctrl_t   ctrl_r;
  i2csf_xstat_t  xs_r, xs_nxt;
  i2csf_state_t  state_r, state_nxt;
  logic [9:0]    txthr_r, rxthr_r;
  logic [IRQ_W-1:0] raw_r, raw_nxt, mask_r;
  logic [31:0]   rdata_r;
  logic [3:0]    bit_r, bit_nxt;
  logic [7:0]    shift_r, shift_nxt;
  logic [10:0]   len_r, len_nxt;
  logic          gc_r, gc_nxt;
  logic          push, slave_write_request_flag_ev, ovf_ev;
  logic          scl_s1, scl_s2, scl_d;
  logic          sda_s1, sda_s2, sda_d;
  logic [7:0]    mem [RX_DEPTH];
  logic [PW-1:0] wptr_r, rptr_r;
  logic [CW-1:0] cnt_r;

  // ****************************************************************
  // pin synchronisers and bus events
  // ****************************************************************
  // two stages before use; only the second stage and its delayed copy are looked at
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
    end
    else if (ce_i)
    begin
      {scl_s1, scl_s2, scl_d} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_i, sda_s1, sda_s2};
    end
  end

  // edge and condition decode
  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire bus_start = scl_s2 & scl_d & ~sda_s2 & sda_d;
  wire bus_stop  = scl_s2 & scl_d & sda_s2 & ~sda_d;
  wire mid_byte = ((state_r == S_RX) || (state_r == S_TX)) &&
                  (bit_r > 4'h1);  // a stop's own scl rise counts one

  // address decode on a completed first byte
  wire       addr_rw  = shift_r[0];
  wire       hit_pri  = shift_r[7:1] == ctrl_r.primary_slave_addr;
  wire       hit_sec  = shift_r[7:1] == ctrl_r.secondary_slave_addr;
  wire       hit_gc   = shift_r == GCALL_AD;
  wire       addr_hit = hit_pri | hit_sec | hit_gc;

  // ****************************************************************
  // rx fifo
  // ****************************************************************
  wire rx_full  = cnt_r == CW'(RX_DEPTH);
  wire rx_empty = cnt_r == '0;
  wire [7:0] rx_head = mem[rptr_r];

  // apb phase decode
  wire apb_setup = psel_i & ~penable_i;
  wire apb_acc   = psel_i & penable_i & ce_i;
  wire wr_acc    = apb_acc & pwrite_i;
  wire rd_acc    = apb_acc & ~pwrite_i;
  wire hit_ctrl  = paddr_i == OFS_CTRL;
  wire hit_xs    = paddr_i == OFS_XSTAT;
  wire hit_rxd   = paddr_i == OFS_RXDATA;
  wire hit_txt   = paddr_i == OFS_TXTHR;
  wire hit_rxt   = paddr_i == OFS_RXTHR;
  wire hit_raw   = paddr_i == OFS_RAW;
  wire hit_mask  = paddr_i == OFS_MASK;
  wire map_hit   = hit_ctrl | hit_xs | hit_rxd | hit_txt | hit_rxt |
                   hit_raw | hit_mask;

  // pops: a bus read pops only what it captured; dma yields to it
  wire bus_pop = rd_acc & hit_rxd & rdata_r[8];           // RULE17
  wire dma_pop = rx_dma_ack_i & ctrl_r.dma_mode & ~rx_empty & ~bus_pop;
  wire pop     = bus_pop | dma_pop;

  // pointer step with wrap for any depth
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(RX_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  // storage has no reset; only pointers and count are control state
  always_ff @(posedge core_clk_i)
  begin
    if (ce_i && push)
      mem[wptr_r] <= shift_r;
  end

  // pointers and level
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end
    else if (ce_i)
    begin
      if (push)
        wptr_r <= ptr_inc(wptr_r);
      if (pop)
        rptr_r <= ptr_inc(rptr_r);                        // RULE10
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end

  // ****************************************************************
  // slave receive sequencer
  // ****************************************************************
  // one byte per hold; the sequencer never pushes into a full fifo
  always_comb
  begin
    state_nxt = state_r;
    bit_nxt   = bit_r;
    shift_nxt = shift_r;
    len_nxt   = len_r;
    xs_nxt    = xs_r;
    gc_nxt    = gc_r;
    push      = 1'b0;
    slave_write_request_flag_ev   = 1'b0;
    ovf_ev    = 1'b0;
    unique case (state_r)
      S_IDLE: ;
      S_ADDR:
      begin
        if (scl_rise)
        begin
          shift_nxt = {shift_r[6:0], sda_s2};
          bit_nxt   = bit_r + 4'h1;
        end
        if (scl_fall && bit_r == BYTE_END)
        begin
          if (addr_hit)
          begin
            state_nxt = S_AACK;
            len_nxt   = '0;
            gc_nxt    = hit_gc;
            xs_nxt.op = addr_rw ? READ_FROM_SLAVE_OP
                                : WRITE_TO_SLAVE_OP;      // RULE1
            xs_nxt.status = XS_BUSY;
            xs_nxt.cause  = '0;
            xs_nxt.rtype  = hit_gc ? RT_GCALL : RT_FRAME;
            xs_nxt.secondary_address_hit = hit_sec & ~hit_pri; // RULE8
            slave_write_request_flag_ev = ~addr_rw;                           // RULE12
          end
          else
            state_nxt = S_IDLE;
        end
      end
      S_AACK:
      begin
        if (scl_fall)
        begin
          state_nxt = rw_of(xs_r.op) ? S_TX : S_RX;
          bit_nxt   = '0;
        end
      end
      S_RX:
      begin
        // data lands lsb first: first bit on the wire in bit 0
        if (scl_rise)
        begin
          shift_nxt = {sda_s2, shift_r[7:1]};             // RULE10
          bit_nxt   = bit_r + 4'h1;
        end
        if (scl_fall && bit_r == BYTE_END)
          state_nxt = S_RHOLD;
      end
      S_RHOLD:
      begin
        if (len_r == LEN_MAX)
        begin
          // no ack is driven, so the master sees nack
          state_nxt     = S_WAIT;                         // RULE5
          xs_nxt.status = XS_ABORT;
          xs_nxt.cause  = OVERFLOW_ABORT;                 // RULE6
          ovf_ev        = 1'b1;
        end
        else if (!rx_full)
        begin
          push      = 1'b1;
          len_nxt   = len_r + 11'h1;                      // RULE3
          state_nxt = S_RACK;
          if (gc_r && len_r == '0 && shift_r[7])
            xs_nxt.rtype = HARDWARE_BROADCAST_CALL;       // RULE2
        end
      end
      S_RACK:
      begin
        if (scl_fall)
        begin
          state_nxt = S_RX;
          bit_nxt   = '0;
        end
      end
      S_TX:
      begin
        // ninth rise samples the master's ack into bit 0
        if (scl_rise)
        begin
          shift_nxt = {shift_r[7:1], sda_s2};
          bit_nxt   = bit_r + 4'h1;
        end
        if (scl_fall && bit_r == ACK_END)
        begin
          bit_nxt = '0;
          len_nxt = (len_r == LEN_MAX) ? '0
                                       : len_r + 11'h1;   // RULE4 RULE7
          if (shift_r[0])
          begin
            state_nxt     = S_WAIT;
            xs_nxt.status = XS_OK;
          end
        end
      end
      S_WAIT: ;
    endcase
    // bus conditions override the sequence
    if (bus_start)
    begin
      if (mid_byte)
      begin
        xs_nxt.status = XS_ABORT;
        xs_nxt.cause  = CAUSE_BERR_START;
      end
      xs_nxt.secondary_address_hit = 1'b0;                // RULE9
      state_nxt = S_ADDR;
      bit_nxt   = '0;
    end
    else if (bus_stop)
    begin
      if (mid_byte)
      begin
        xs_nxt.status = XS_ABORT;
        xs_nxt.cause  = CAUSE_BERR_STOP;
      end
      else if (xs_r.status == XS_BUSY)
        xs_nxt.status = XS_OK;
      xs_nxt.secondary_address_hit = 1'b0;                // RULE9
      state_nxt = S_IDLE;
    end
    if (!ctrl_r.peripheral_on)
    begin
      xs_nxt.secondary_address_hit = 1'b0;                // RULE9
      state_nxt = S_IDLE;
    end
    xs_nxt.length  = len_nxt[9:0];
    xs_nxt.rsv_hi  = '0;                                  // RULE18
    xs_nxt.rsv_mid = '0;
  end

  // direction bit of the current slave operation
  function automatic logic rw_of(input logic [1:0] op);
    rw_of = op == READ_FROM_SLAVE_OP;
  endfunction : rw_of

  // sequencer state
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      state_r <= S_IDLE;
      bit_r   <= '0;
      shift_r <= '0;
      len_r   <= '0;
      gc_r    <= 1'b0;
      xs_r    <= REG_RST;
    end
    else if (ce_i)
    begin
      state_r <= state_nxt;
      bit_r   <= bit_nxt;
      shift_r <= shift_nxt;
      len_r   <= len_nxt;
      gc_r    <= gc_nxt;
      xs_r    <= xs_nxt;
    end
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  // open drain: only ever pull low; stretch only while scl is low
  assign scl_o    = 1'b0;
  assign scl_oe_o = (state_r == S_RHOLD) & rx_full & ~scl_s2; // RULE11
  assign sda_o    = 1'b0;
  assign sda_oe_o = (state_r == S_AACK) | (state_r == S_RACK);

  // ****************************************************************
  // thresholds, interrupts, dma
  // ****************************************************************
  wire txne_lvl = tx_level_i <= txthr_r;                  // RULE15
  wire rxnf_lvl = 10'(cnt_r) >= rxthr_r;                  // RULE16
  wire [IRQ_W-1:0] irq_ev  = {ovf_ev, slave_write_request_flag_ev, rxnf_lvl, txne_lvl};
  wire [IRQ_W-1:0] raw_clr = (rd_acc & hit_raw) ? rdata_r[IRQ_W-1:0]
                                                : '0;

  // set wins over the read clear
  always_comb
  begin
    raw_nxt = (raw_r & ~raw_clr) | irq_ev;
  end

  assign irq_o         = |(raw_r & mask_r);
  assign rx_dma_req_o  = ctrl_r.dma_mode & ~rx_empty;     // RULE14
  assign rx_dma_data_o = rx_head;

  // ****************************************************************
  // apb register file
  // ****************************************************************
  // read mux; reserved bits are zero by construction
  wire [31:0] rd_mux =
    hit_ctrl ? 32'(ctrl_r)                                :
    hit_xs   ? 32'(xs_r)                                  :
    hit_rxd  ? (rx_empty ? 32'h0 : {23'h0, 1'b1, rx_head}) :
    hit_txt  ? {22'h0, txthr_r}                           :
    hit_rxt  ? {22'h0, rxthr_r}                           :
    hit_raw  ? {28'h0, raw_r}                             :
    hit_mask ? {28'h0, mask_r}                            : 32'h0;

  // capture in setup so read side effects match what is returned
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      rdata_r <= '0;
    else if (ce_i && apb_setup)
      rdata_r <= rd_mux;
  end

  // writable registers and sticky status
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      ctrl_r  <= REG_RST;
      txthr_r <= THR_RST;
      rxthr_r <= THR_RST;
      mask_r  <= '0;
      raw_r   <= '0;
    end
    else if (ce_i)
    begin
      raw_r <= raw_nxt;
      if (wr_acc && hit_ctrl)
        ctrl_r <= pwdata_i & 32'h007f_7f03;               // RULE18
      if (wr_acc && hit_txt)
        txthr_r <= pwdata_i[9:0];
      if (wr_acc && hit_rxt)
        rxthr_r <= pwdata_i[9:0];
      if (wr_acc && hit_mask)
        mask_r <= pwdata_i[IRQ_W-1:0];
    end
  end

  // data byte only; the captured valid bit stays internal
  assign prdata_o  = hit_rxd ? {24'h0, rdata_r[7:0]} : rdata_r; // RULE17
  assign pready_o  = ce_i;
  assign pslverr_o = psel_i & penable_i & ~map_hit;

endmodule : i2csf_top
`default_nettype wire
